// ### hw/pls_top.sv
`timescale 1ns/1ps
module pls_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] term_in,
  input wire logic start_in,
  input wire logic jog_in,
  input wire logic homing_done_in,
  input wire logic homing_set_fail_in,
  input wire logic [15:0] speed_cmd_in,
  input wire logic signed [15:0] cmd_inc_in,
  input wire logic signed [15:0] fb_inc_in,
  output logic [2:0] term_out,
  output logic [15:0] speed_out,
  output logic pos_start_out,
  output logic ccw_inhibit_out,
  output logic cw_inhibit_out,
  output logic homing_complete_out,
  output logic homing_failure_out,
  output logic stroke_limit_warning_out
);
  import pls_pkg::*;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [2:0] pol_r;
  logic [1:0] roll_r;
  logic method_r;
  logic [7:0] encdir_r;
  logic [23:0] infn_r;
  logic [23:0] outfn_r;
  logic [15:0] ssdec_r;
  logic [15:0] cmddec_r;
  logic seterr_r;
  logic uncomp_r;
  logic complete_r;
  logic reject_r;
  logic ccw_inh_r;
  logic cw_inh_r;
  logic signed [31:0] curpos_r;
  logic signed [31:0] poscmd_r;
  pls_stop_e state_r;

  logic wr_en;
  logic setup;
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Three stages; a new level is accepted only when stages two and three
  // agree, which also rejects a single-cycle glitch on the terminal.
  logic [4:0] pin_raw;
  logic [4:0] s1_r;
  logic [4:0] s2_r;
  logic [4:0] s3_r;
  logic [4:0] pin_r;
  assign pin_raw = {jog_in, start_in, term_in};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 5'h00;
      s2_r <= 5'h00;
      s3_r <= 5'h00;
      pin_r <= 5'h00;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_r <= (pin_r & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
    end
  end

  // ----------------------------------------------------------------
  // Input function routing and polarity
  // ----------------------------------------------------------------
  logic [2:0] is_ss;
  logic [2:0] is_fwd;
  logic [2:0] is_rev;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_infn
      assign is_ss[gi] = infn_r[gi*8 +: 8] == PLS_FN_SUDDEN;
      assign is_fwd[gi] = infn_r[gi*8 +: 8] == PLS_FN_FWD_LIMIT;
      assign is_rev[gi] = infn_r[gi*8 +: 8] == PLS_FN_REV_LIMIT;
    end
  endgenerate

  // An unassigned function never acts, whatever its polarity digit says.
  logic ss_act;
  logic fwd_act;
  logic rev_act;
  logic lim_act;
  assign ss_act = |(is_ss & (pin_r[2:0] ^ {3{pol_r[0]}}));
  assign fwd_act = |(is_fwd & (pin_r[2:0] ^ {3{pol_r[1]}}));
  assign rev_act = |(is_rev & (pin_r[2:0] ^ {3{pol_r[2]}}));
  assign lim_act = fwd_act || rev_act;

  // ----------------------------------------------------------------
  // Start qualification
  // ----------------------------------------------------------------
  logic start_d_r;
  logic start_edge;
  logic roll_on;
  logic start_ok;
  assign start_edge = pin_r[3] && !start_d_r;
  assign roll_on = roll_r != PLS_ROLL_OFF;
  assign start_ok = complete_r || pin_r[4] || roll_on;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_d_r <= 1'b0;
      pos_start_out <= 1'b0;
    end else begin
      start_d_r <= pin_r[3];
      pos_start_out <= start_edge && start_ok && method_r &&
                       state_r == PLS_RUN;
    end
  end

  // ----------------------------------------------------------------
  // Homing flags
  // ----------------------------------------------------------------
  logic clr_st;
  assign clr_st = wr_en && paddr == PLS_STATUS_OFS;

  // Set wins over a software clear landing in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seterr_r <= 1'b0;
    end else if (homing_set_fail_in) begin
      seterr_r <= 1'b1;
    end else if (clr_st && pwdata[PLS_ST_SETERR]) begin
      seterr_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uncomp_r <= 1'b0;
    end else if (start_edge && !complete_r && !roll_on) begin
      uncomp_r <= 1'b1;
    end else if (clr_st && pwdata[PLS_ST_UNCOMP]) begin
      uncomp_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      complete_r <= 1'b0;
    end else if (homing_done_in) begin
      complete_r <= 1'b1;
    end else if (homing_set_fail_in) begin
      complete_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Stop sequencer and slope
  // ----------------------------------------------------------------
  // Stroke ends stop only under position control; the sudden stop always.
  logic stop_req;
  logic lim_stop;
  logic [15:0] eff_time;
  logic [9:0] tick_cnt_r;
  logic [15:0] step_cnt_r;
  logic tick;
  assign lim_stop = lim_act && method_r;
  assign stop_req = ss_act || lim_stop;
  assign eff_time = (ssdec_r > cmddec_r) ? cmddec_r : ssdec_r;
  assign tick = tick_cnt_r == PLS_SLOPE_TICK_CYC - 10'h001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 10'h000;
    end else if (tick) begin
      tick_cnt_r <= 10'h000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 10'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= PLS_RUN;
      speed_out <= 16'h0000;
      step_cnt_r <= 16'h0000;
    end else begin
      case (state_r)
        PLS_RUN: begin
          speed_out <= speed_cmd_in;
          step_cnt_r <= 16'h0000;
          if (stop_req) begin
            state_r <= PLS_DECEL;
            speed_out <= speed_out;
          end
        end
        PLS_DECEL: begin
          // Speed falls by one unit every eff_time slope ticks.
          if (speed_out == 16'h0000) begin
            state_r <= PLS_HELD;
          end else if (tick) begin
            if (step_cnt_r + 16'h0001 >= eff_time) begin
              step_cnt_r <= 16'h0000;
              speed_out <= speed_out - 16'h0001;
            end else begin
              step_cnt_r <= step_cnt_r + 16'h0001;
            end
          end
        end
        PLS_HELD: begin
          speed_out <= 16'h0000;
          // A held stroke stop is released; the inhibits keep guarding.
          if (!ss_act) begin
            state_r <= PLS_RUN;
          end
        end
        default: begin
          state_r <= PLS_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Direction inhibits
  // ----------------------------------------------------------------
  logic swap;
  logic stopped;
  assign swap = encdir_r == PLS_ENC_SWAPPED;
  assign stopped = state_r == PLS_HELD || (state_r == PLS_DECEL &&
                   speed_out == 16'h0000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccw_inh_r <= 1'b0;
      cw_inh_r <= 1'b0;
    end else begin
      if (!(swap ? rev_act : fwd_act) || !method_r) begin
        ccw_inh_r <= 1'b0;
      end else if (stopped) begin
        ccw_inh_r <= 1'b1;
      end
      if (!(swap ? fwd_act : rev_act) || !method_r) begin
        cw_inh_r <= 1'b0;
      end else if (stopped) begin
        cw_inh_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Position counters and roll feed
  // ----------------------------------------------------------------
  logic signed [31:0] droop;
  assign droop = poscmd_r - curpos_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      curpos_r <= 32'sh00000000;
      poscmd_r <= 32'sh00000000;
    end else if (pos_start_out && roll_r == PLS_ROLL_MODE1) begin
      curpos_r <= 32'sh00000000;
      poscmd_r <= 32'sh00000000;
    end else if (pos_start_out && roll_r == PLS_ROLL_MODE2) begin
      curpos_r <= curpos_r - droop;
      poscmd_r <= 32'sh00000000;
    end else begin
      curpos_r <= curpos_r + 32'(fb_inc_in);
      poscmd_r <= poscmd_r + 32'(cmd_inc_in);
    end
  end

  // ----------------------------------------------------------------
  // Output terminals
  // ----------------------------------------------------------------
  logic [2:0] term_nxt;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_outfn
      always_comb begin
        case (outfn_r[gi*8 +: 8])
          PLS_OF_WARN_POS: term_nxt[gi] = lim_act;
          PLS_OF_WARN_NEG: term_nxt[gi] = !lim_act;
          PLS_OF_FAIL_POS: term_nxt[gi] = seterr_r || uncomp_r;
          PLS_OF_FAIL_NEG: term_nxt[gi] = !(seterr_r || uncomp_r);
          PLS_OF_DONE_POS: term_nxt[gi] = complete_r;
          PLS_OF_DONE_NEG: term_nxt[gi] = !complete_r;
          default: term_nxt[gi] = 1'b0;
        endcase
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_out <= 3'h0;
      ccw_inhibit_out <= 1'b0;
      cw_inhibit_out <= 1'b0;
      homing_complete_out <= 1'b0;
      homing_failure_out <= 1'b0;
      stroke_limit_warning_out <= 1'b0;
    end else begin
      term_out <= term_nxt;
      ccw_inhibit_out <= ccw_inh_r;
      cw_inhibit_out <= cw_inh_r;
      homing_complete_out <= complete_r;
      homing_failure_out <= seterr_r || uncomp_r;
      stroke_limit_warning_out <= lim_act;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_r <= PLS_POL_RST;
      roll_r <= PLS_ROLL_RST;
      encdir_r <= PLS_ENCDIR_RST;
      infn_r <= PLS_INFN_RST;
      outfn_r <= PLS_OUTFN_RST;
      ssdec_r <= PLS_SSDEC_RST;
      cmddec_r <= PLS_CMDDEC_RST;
    end else if (wr_en) begin
      case (paddr)
        PLS_CFG_OFS: begin
          pol_r <= pwdata[PLS_CFG_POL_LSB +: 3];
          roll_r <= pwdata[PLS_CFG_ROLL_LSB +: 2];
        end
        PLS_ENCDIR_OFS: encdir_r <= pwdata[7:0];
        PLS_INFN_OFS: infn_r <= pwdata[23:0];
        PLS_OUTFN_OFS: outfn_r <= pwdata[23:0];
        // A zero time would step the slope like one, so it is stored as one.
        PLS_SSDEC_OFS: ssdec_r <= (pwdata[15:0] == 16'h0000) ?
                                  16'h0001 : pwdata[15:0];
        PLS_CMDDEC_OFS: cmddec_r <= (pwdata[15:0] == 16'h0000) ?
                                    16'h0001 : pwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      method_r <= PLS_METHOD_RST;
      reject_r <= 1'b0;
    end else if (wr_en && paddr == PLS_METHOD_OFS) begin
      if (lim_act && pwdata[0] != method_r) begin
        reject_r <= 1'b1;
      end else begin
        method_r <= pwdata[0];
      end
    end else if (clr_st && pwdata[PLS_ST_REJECT]) begin
      reject_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------
  // Data and error are captured in the setup cycle, so every transfer
  // completes in its first access cycle with no wait state.
  logic [31:0] rd_nxt;
  logic err_nxt;
  always_comb begin
    rd_nxt = 32'h00000000;
    err_nxt = 1'b0;
    case (paddr)
      PLS_CFG_OFS: begin
        rd_nxt[PLS_CFG_POL_LSB +: 3] = pol_r;
        rd_nxt[PLS_CFG_ROLL_LSB +: 2] = roll_r;
      end
      PLS_METHOD_OFS: rd_nxt[0] = method_r;
      PLS_ENCDIR_OFS: rd_nxt[7:0] = encdir_r;
      PLS_INFN_OFS: rd_nxt[23:0] = infn_r;
      PLS_OUTFN_OFS: rd_nxt[23:0] = outfn_r;
      PLS_SSDEC_OFS: rd_nxt[15:0] = ssdec_r;
      PLS_CMDDEC_OFS: rd_nxt[15:0] = cmddec_r;
      PLS_STATUS_OFS: begin
        rd_nxt[PLS_ST_SETERR] = seterr_r;
        rd_nxt[PLS_ST_UNCOMP] = uncomp_r;
        rd_nxt[PLS_ST_COMPLETE] = complete_r;
        rd_nxt[PLS_ST_WARN] = lim_act;
        rd_nxt[PLS_ST_CCWINH] = ccw_inh_r;
        rd_nxt[PLS_ST_CWINH] = cw_inh_r;
        rd_nxt[PLS_ST_STATE_LSB +: 2] = state_r;
        rd_nxt[PLS_ST_REJECT] = reject_r;
      end
      PLS_CURPOS_OFS: rd_nxt = curpos_r;
      PLS_POSCMD_OFS: rd_nxt = poscmd_r;
      default: err_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup && err_nxt;
      if (setup) begin
        prdata <= pwrite ? 32'h00000000 : rd_nxt;
      end
    end
  end

endmodule

// ### common/pls_pkg.sv
package pls_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on APB)
  // ----------------------------------------------------------------
  localparam logic [7:0] PLS_CFG_OFS = 8'h00;
  localparam logic [7:0] PLS_METHOD_OFS = 8'h04;
  localparam logic [7:0] PLS_ENCDIR_OFS = 8'h08;
  localparam logic [7:0] PLS_INFN_OFS = 8'h0c;
  localparam logic [7:0] PLS_OUTFN_OFS = 8'h10;
  localparam logic [7:0] PLS_SSDEC_OFS = 8'h14;
  localparam logic [7:0] PLS_CMDDEC_OFS = 8'h18;
  localparam logic [7:0] PLS_STATUS_OFS = 8'h1c;
  localparam logic [7:0] PLS_CURPOS_OFS = 8'h20;
  localparam logic [7:0] PLS_POSCMD_OFS = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PLS_CFG_POL_LSB = 0;
  localparam int PLS_CFG_ROLL_LSB = 8;
  localparam int PLS_ST_SETERR = 0;
  localparam int PLS_ST_UNCOMP = 1;
  localparam int PLS_ST_COMPLETE = 2;
  localparam int PLS_ST_WARN = 3;
  localparam int PLS_ST_CCWINH = 4;
  localparam int PLS_ST_CWINH = 5;
  localparam int PLS_ST_STATE_LSB = 6;
  localparam int PLS_ST_REJECT = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] PLS_POL_RST = 3'h0;
  localparam logic [1:0] PLS_ROLL_RST = 2'h0;
  localparam logic PLS_METHOD_RST = 1'b0;
  localparam logic [7:0] PLS_ENCDIR_RST = 8'h65;
  localparam logic [23:0] PLS_INFN_RST = 24'h000000;
  localparam logic [23:0] PLS_OUTFN_RST = 24'h000000;
  localparam logic [15:0] PLS_SSDEC_RST = 16'h0001;
  localparam logic [15:0] PLS_CMDDEC_RST = 16'h0001;

  // ----------------------------------------------------------------
  // Codes and settings
  // ----------------------------------------------------------------
  localparam logic [7:0] PLS_FN_SUDDEN = 8'h57;
  localparam logic [7:0] PLS_FN_FWD_LIMIT = 8'h58;
  localparam logic [7:0] PLS_FN_REV_LIMIT = 8'h59;
  localparam logic [7:0] PLS_OF_WARN_POS = 8'h18;
  localparam logic [7:0] PLS_OF_WARN_NEG = 8'h7c;
  localparam logic [7:0] PLS_OF_FAIL_POS = 8'h38;
  localparam logic [7:0] PLS_OF_FAIL_NEG = 8'h9c;
  localparam logic [7:0] PLS_OF_DONE_POS = 8'h3f;
  localparam logic [7:0] PLS_OF_DONE_NEG = 8'ha3;
  localparam logic [7:0] PLS_ENC_SWAPPED = 8'h64;
  localparam logic [1:0] PLS_ROLL_OFF = 2'h0;
  localparam logic [1:0] PLS_ROLL_MODE1 = 2'h1;
  localparam logic [1:0] PLS_ROLL_MODE2 = 2'h2;

  // ----------------------------------------------------------------
  // Timing: decel times count in slope ticks
  // ----------------------------------------------------------------
  localparam int PLS_CLK_NS = 10;
  localparam int PLS_SLOPE_TICK_NS = 10000;
  localparam logic [9:0] PLS_SLOPE_TICK_CYC =
    10'(PLS_SLOPE_TICK_NS / PLS_CLK_NS);

  typedef enum logic [1:0] {
    PLS_RUN = 2'b00,
    PLS_DECEL = 2'b01,
    PLS_HELD = 2'b10
  } pls_stop_e;

endpackage

// ### verif/pls_assertions.sv
`timescale 1ns/1ps
module pls_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic jog_in,
  input wire logic homing_done_in,
  input wire logic homing_set_fail_in,
  input wire logic [15:0] speed_out,
  input wire logic pos_start_out,
  input wire logic ccw_inhibit_out,
  input wire logic cw_inhibit_out,
  input wire logic homing_complete_out,
  input wire logic homing_failure_out
);
  import pls_pkg::*;
  logic [1:0] roll_r;
  logic [3:0] clr_r;
  logic wr_done;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------------------------
  // Bus shadow
  // ----------------------------
  // Roll mode and recent flag clears are mirrored from finished writes,
  // because the registers themselves are out of sight here.
  assign wr_done = psel && penable && pready && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      roll_r <= PLS_ROLL_OFF;
      clr_r <= 4'h0;
    end else begin
      if (wr_done && paddr == PLS_CFG_OFS) begin
        roll_r <= pwdata[PLS_CFG_ROLL_LSB +: 2];
      end
      clr_r <= {clr_r[2:0],
                wr_done && paddr == PLS_STATUS_OFS && |pwdata[1:0]};
    end
  end
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence done_s;
    homing_done_in && !homing_set_fail_in;
  endsequence
  // ----------------------------
  // Properties
  // ----------------------------
  pready_ans_a: assert property (setup_s |=> pready)
    else $error("no answer after setup");
  pready_cause_a: assert property (pready |-> $past(psel && !penable))
    else $error("answer without setup");
  slverr_with_a: assert property (pslverr |-> pready)
    else $error("error flag outside access");
  fail_rise_a: assert property (
    homing_set_fail_in |-> ##[1:3] homing_failure_out)
    else $error("failure output missing after set error");
  done_rise_a: assert property (
    done_s |-> ##[1:3] homing_complete_out)
    else $error("complete output missing after homing");
  fail_hold_a: assert property (
    $fell(homing_failure_out) |-> clr_r != 4'h0)
    else $error("failure output dropped without clear");
  start_gate_a: assert property (
    pos_start_out && roll_r == PLS_ROLL_OFF && !jog_in
      |-> homing_complete_out)
    else $error("start accepted without homing");
  start_pulse_a: assert property (pos_start_out |=> !pos_start_out)
    else $error("start pulse longer than one cycle");
  inhibit_stop_a: assert property (
    $rose(ccw_inhibit_out || cw_inhibit_out) |-> speed_out == 16'h0 ||
      $past(speed_out) == 16'h0 || $past(speed_out, 2) == 16'h0)
    else $error("inhibit set while moving");
endmodule

// ### verif/pls_ctrl_model.sv
`timescale 1ns/1ps
module pls_ctrl_model #(
  parameter int SEL_GAP = 50,
  parameter int HOLD = 200
) (
  input wire logic pclk,
  output logic start_in,
  output logic jog_in,
  output logic [2:0] term_in
);
  // The millisecond gaps are scaled down; the block does not time them,
  // so only their order and rough proportion matter.
  initial begin
    start_in = 1'b0;
    jog_in = 1'b0;
    term_in = 3'h0;
  end
  task automatic set_pins(input logic [2:0] v);
    @(posedge pclk);
    term_in <= v;
  endtask
  task automatic start(input logic jog, input int lag);
    @(posedge pclk);
    jog_in <= jog;
    repeat (SEL_GAP + lag) @(posedge pclk);
    start_in <= 1'b1;
    repeat (HOLD) @(posedge pclk);
    start_in <= 1'b0;
    jog_in <= 1'b0;
  endtask
endmodule

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import pls_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic homing_done_in = 1'b0;
  logic homing_set_fail_in = 1'b0;
  logic [15:0] speed_cmd_in;
  logic signed [15:0] cmd_inc_in = 16'sh0;
  logic signed [15:0] fb_inc_in = 16'sh0;
  logic [31:0] prdata;
  logic pready, pslverr, start_in, jog_in, pos_start_out, warn;
  logic ccw_inhibit_out, cw_inhibit_out, homing_complete_out, fail;
  logic [2:0] term_in, term_out;
  logic [15:0] speed_out;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  int starts = 0;
  int a, b, n, t, r, s;
  always #5 pclk = ~pclk;
  pls_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .term_in(term_in), .start_in(start_in), .jog_in(jog_in),
    .homing_done_in(homing_done_in), .homing_set_fail_in(homing_set_fail_in),
    .speed_cmd_in(speed_cmd_in), .cmd_inc_in(cmd_inc_in),
    .fb_inc_in(fb_inc_in), .term_out(term_out), .speed_out(speed_out),
    .pos_start_out(pos_start_out), .ccw_inhibit_out(ccw_inhibit_out),
    .cw_inhibit_out(cw_inhibit_out), .homing_failure_out(fail),
    .homing_complete_out(homing_complete_out),
    .stroke_limit_warning_out(warn));
  pls_ctrl_model m (.pclk(pclk), .start_in(start_in), .jog_in(jog_in),
    .term_in(term_in));
  task automatic complete_run();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] x,
                     input logic [31:0] g);
    compares++;
    if (g !== x) begin
      err_total++;
      $display("unexpected %s exp %h got %h", s, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] x,
                    input logic er);
    exp_q.push_back({er, x});
    apb(1'b0, ad, $urandom());
  endtask
  task automatic pulse(input logic f);
    @(posedge pclk);
    homing_set_fail_in <= f;
    homing_done_in <= !f;
    @(posedge pclk);
    homing_set_fail_in <= 1'b0;
    homing_done_in <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic wait_zero(input int lo, input int hi);
    n = 0;
    while (speed_out !== 16'h0 && n <= hi) begin
      @(posedge pclk);
      n++;
    end
    chk("stop time", 32'h1, 32'(n >= lo && n <= hi));
    repeat (4) @(posedge pclk);
  endtask
  task automatic starts_are(input int k);
    m.start(1'b0, $urandom_range(0, 20));
    repeat (4) @(posedge pclk);
    chk("starts", 32'(k), 32'(starts));
  endtask
  // Read answers are judged here, in order, as they appear on the bus.
  always @(posedge pclk) begin
    cyc++;
    if (pos_start_out === 1'b1) starts++;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = exp_q.pop_front();
      compares++;
      if ({pslverr, prdata} !== e) begin
        err_total++;
        $display("unexpected read %h exp %h got %h", paddr, e,
                 {pslverr, prdata});
      end
    end
    if (cyc > 60000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    t = $urandom(32'h9482);
    s = $urandom_range(2, 4);
    speed_cmd_in <= 16'(s);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(PLS_CFG_OFS, 32'h0, 1'b0);
    rd(PLS_ENCDIR_OFS, 32'(PLS_ENCDIR_RST), 1'b0);
    rd(PLS_SSDEC_OFS, 32'(PLS_SSDEC_RST), 1'b0);
    rd(8'h40 + 8'($urandom_range(0, 15)) * 8'h04, 32'h0, 1'b1);
    apb(1'b1, PLS_INFN_OFS, {8'h0, PLS_FN_REV_LIMIT, PLS_FN_FWD_LIMIT,
        PLS_FN_SUDDEN});
    apb(1'b1, PLS_OUTFN_OFS, {8'h0, PLS_OF_DONE_NEG, PLS_OF_FAIL_POS,
        PLS_OF_WARN_POS});
    pulse(1'b1);
    chk("term out", 32'h6, 32'(term_out));
    rd(PLS_STATUS_OFS, 32'h1, 1'b0);
    apb(1'b1, PLS_STATUS_OFS, 32'h1);
    repeat (3) @(posedge pclk);
    chk("fail out", 32'h0, 32'(fail));
    apb(1'b1, PLS_METHOD_OFS, 32'h1);
    starts_are(0);
    rd(PLS_STATUS_OFS, 32'h2, 1'b0);
    chk("fail out", 32'h1, 32'(fail));
    apb(1'b1, PLS_STATUS_OFS, 32'h2);
    pulse(1'b0);
    chk("done out", 32'h1, 32'(homing_complete_out));
    starts_are(1);
    pulse(1'b1);
    m.start(1'b1, 0);
    starts_are(2);
    apb(1'b1, PLS_STATUS_OFS, 32'h3);
    for (int i = 1; i < 3; i++) begin
      apb(1'b1, PLS_CFG_OFS, 32'(i) << PLS_CFG_ROLL_LSB);
      a = $urandom_range(1, 99);
      b = $urandom_range(1, 99);
      @(posedge pclk);
      cmd_inc_in <= 16'(a);
      fb_inc_in <= 16'(b);
      repeat (10) @(posedge pclk);
      cmd_inc_in <= 16'sh0;
      fb_inc_in <= 16'sh0;
      starts_are(2 + i);
      rd(PLS_CURPOS_OFS, i == 1 ? 32'h0 : 32'(20 * b - 10 * a), 1'b0);
      rd(PLS_POSCMD_OFS, 32'h0, 1'b0);
    end
    apb(1'b1, PLS_CFG_OFS, 32'h0);
    for (int i = 0; i < 2; i++) begin
      r = i ? 1 : 2;
      apb(1'b1, PLS_SSDEC_OFS, i ? 32'h4 : 32'h2);
      apb(1'b1, PLS_CMDDEC_OFS, i ? 32'h1 : 32'h3);
      m.set_pins(3'b001);
      wait_zero(1000 * (s * r - 1), 1000 * s * r + 20);
      rd(PLS_STATUS_OFS, 32'h80, 1'b0);
      m.set_pins(3'b000);
      repeat (10) @(posedge pclk);
      chk("speed", 32'(s), 32'(speed_out));
    end
    apb(1'b1, PLS_CFG_OFS, 32'h1);
    repeat (20) @(posedge pclk);
    rd(PLS_STATUS_OFS, 32'h40, 1'b0);
    m.set_pins(3'b001);
    wait_zero(0, 1000 * s + 100);
    m.set_pins(3'b011);
    wait_zero(1000 * (s - 1), 1000 * s + 20);
    chk("term out", 32'h5, 32'(term_out));
    chk("inhibit", 32'h1, 32'({cw_inhibit_out, ccw_inhibit_out}));
    apb(1'b1, PLS_METHOD_OFS, 32'h0);
    rd(PLS_METHOD_OFS, 32'h1, 1'b0);
    apb(1'b1, PLS_ENCDIR_OFS, 32'(PLS_ENC_SWAPPED));
    wait_zero(0, 3100);
    chk("inhibit", 32'h2, 32'({cw_inhibit_out, ccw_inhibit_out}));
    apb(1'b1, PLS_CFG_OFS, 32'h5);
    repeat (8) @(posedge pclk);
    wait_zero(0, 3100);
    chk("inhibit", 32'h3, 32'({cw_inhibit_out, ccw_inhibit_out}));
    m.set_pins(3'b101);
    repeat (8) @(posedge pclk);
    chk("warn", 32'h0, 32'({cw_inhibit_out, ccw_inhibit_out, warn}));
    m.set_pins(3'b001);
    repeat (8) @(posedge pclk);
    wait_zero(0, 1000 * s + 100);
    chk("inhibit", 32'h1, 32'({cw_inhibit_out, ccw_inhibit_out}));
    m.set_pins(3'b101);
    repeat (8) @(posedge pclk);
    apb(1'b1, PLS_METHOD_OFS, 32'h0);
    m.set_pins(3'b111);
    repeat (1200) @(posedge pclk);
    chk("warn", 32'h1, 32'(warn));
    chk("speed", 32'(s), 32'(speed_out));
    apb(1'b1, PLS_OUTFN_OFS, {8'h0, PLS_OF_DONE_POS, PLS_OF_FAIL_NEG,
        PLS_OF_WARN_NEG});
    repeat (3) @(posedge pclk);
    chk("term out", 32'h2, 32'(term_out));
    complete_run();
  end
endmodule
bind pls_top pls_assertions chk_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .jog_in(jog_in),
  .homing_done_in(homing_done_in), .homing_set_fail_in(homing_set_fail_in),
  .speed_out(speed_out), .pos_start_out(pos_start_out),
  .ccw_inhibit_out(ccw_inhibit_out), .cw_inhibit_out(cw_inhibit_out),
  .homing_complete_out(homing_complete_out),
  .homing_failure_out(homing_failure_out));
